// [kwu_pkg.sv]
package kwu_pkg;

  // geometry
  localparam int          KWU_NUM_KEYS        = 4;

  // register byte offsets
  localparam logic [7:0]  KWU_CONFIG0_OFFSET  = 8'h00;
  localparam logic [7:0]  KWU_CONFIG1_OFFSET  = 8'h04;
  localparam logic [7:0]  KWU_CONFIG2_OFFSET  = 8'h08;
  localparam logic [7:0]  KWU_CONFIG3_OFFSET  = 8'h0c;
  localparam logic [7:0]  KWU_STATUS_OFFSET   = 8'h10;
  localparam logic [7:0]  KWU_PULLUP_OFFSET   = 8'h14;
  localparam logic [7:0]  KWU_ROUTE_OFFSET    = 8'h18;

  // key_wake_config field positions
  localparam int          KWU_SEL_LSB         = 0;
  localparam int          KWU_EN_BIT          = 4;

  // reset values
  localparam logic [3:0]  KWU_PULLUP_RESET    = 4'h0;
  localparam logic [1:0]  KWU_SEL_RESET       = 2'h0;
  localparam logic        KWU_EN_RESET        = 1'b0;
  localparam logic        KWU_ROUTE_RESET     = 1'b0;

  // active-state encodings of key_active_select
  localparam logic [1:0]  KWU_SEL_RISE        = 2'h0;
  localparam logic [1:0]  KWU_SEL_FALL        = 2'h1;
  localparam logic [1:0]  KWU_SEL_HIGH        = 2'h2;
  localparam logic [1:0]  KWU_SEL_LOW         = 2'h3;

  // axi response codes
  localparam logic [1:0]  KWU_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  KWU_RESP_SLVERR     = 2'h2;

endpackage

// [kwu_key_detect.sv]
`timescale 1ns/1ns
// per-key synchroniser and active-state detector
module kwu_key_detect
  import kwu_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // pin and settings
  input  wire logic       key_pin,
  input  wire logic [1:0] key_active_select,
  // detection
  output logic            key_active
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two-stage synchroniser, then one history stage for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= key_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire rise_det = sync2_reg & ~prev_reg;
  wire fall_det = ~sync2_reg & prev_reg;

  // detection always running with the live select
  always_comb begin
    key_active = 1'b0;
    unique case (key_active_select)
      KWU_SEL_RISE: key_active = rise_det;
      KWU_SEL_FALL: key_active = fall_det;
      KWU_SEL_HIGH: key_active = sync2_reg;
      KWU_SEL_LOW:  key_active = ~sync2_reg;
    endcase
  end

endmodule

// [kwu_key_wakeup.sv]
`timescale 1ns/1ns
// Functional notes
// - four keys merged into one shared request output
// - each key has an enable; disabled keys never set flags
// - two-bit select: rising edge, falling edge, high or low level
// - detection runs continuously using the current select value
// - enabled key with active condition sets its status flag to 1
// - status is read-only; a read returns and clears flags, writes ignored
// - level-mode flag stays 1 after read while input stays active
// - clearing on first request clears all pending key requests together
// - detection after clearing read sets a new request, never lost
// - combined result is active-high level to clock generator and interrupt controller
// - stop_release_select 1 routes keys to stop release, default 0 interrupts
// - per-key pull-up bit: 1 enables pull-up, 0 disables
module kwu_key_wakeup
  import kwu_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // key pins
  input  wire logic [3:0]  key_in,
  output logic [3:0]       key_pullup_en,
  // request outputs
  output logic             key_irq_req,
  output logic             key_wake_req
);

  localparam int N = KWU_NUM_KEYS;

  logic [1:0]   sel_reg [N];
  logic [N-1:0] en_reg;
  logic [N-1:0] pullup_reg;
  logic         route_reg;
  logic [N-1:0] status_reg;
  logic [N-1:0] status_next;
  logic [N-1:0] key_hit;

  logic         aw_held_reg;
  logic [7:0]   aw_addr_reg;
  logic         w_held_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;

  // ---------------- write channel ----------------
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  wire   aw_fire       = s_axi_awvalid & s_axi_awready;
  wire   w_fire        = s_axi_wvalid & s_axi_wready;
  wire   wr_do         = aw_held_reg & w_held_reg & ~bvalid_reg;

  wire   wr_cfg_hit    = (aw_addr_reg[7:4] == 4'h0) && (aw_addr_reg[1:0] == 2'h0);
  wire   [1:0] wr_key  = aw_addr_reg[3:2];
  wire   wr_status     = (aw_addr_reg == KWU_STATUS_OFFSET);
  wire   wr_pullup     = (aw_addr_reg == KWU_PULLUP_OFFSET);
  wire   wr_route      = (aw_addr_reg == KWU_ROUTE_OFFSET);
  wire   wr_mapped     = wr_cfg_hit | wr_status | wr_pullup | wr_route;
  wire   wr_lane0      = w_strb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= KWU_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_mapped ? KWU_RESP_OKAY : KWU_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ---------------- control registers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_reg <= KWU_PULLUP_RESET;
      route_reg  <= KWU_ROUTE_RESET;
    end else if (wr_do && wr_lane0) begin
      if (wr_pullup) begin
        pullup_reg <= w_data_reg[N-1:0];
      end
      if (wr_route) begin
        route_reg <= w_data_reg[0];
      end
    end
  end

  assign key_pullup_en = pullup_reg;

  // ---------------- per-key config and detection ----------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_key
      logic key_active;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sel_reg[g] <= KWU_SEL_RESET;
          en_reg[g]  <= KWU_EN_RESET;
        end else if (wr_do && wr_lane0 && wr_cfg_hit && wr_key == 2'(g)) begin
          sel_reg[g] <= w_data_reg[KWU_SEL_LSB +: 2];
          en_reg[g]  <= w_data_reg[KWU_EN_BIT];
        end
      end

      // synchronised, always-on detector
      kwu_key_detect u_detect (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .key_pin           (key_in[g]),
        .key_active_select (sel_reg[g]),
        .key_active        (key_active)
      );

      assign key_hit[g] = en_reg[g] & key_active;
    end
  endgenerate

  // ---------------- read channel ----------------
  assign s_axi_arready = ~rvalid_reg;
  wire   ar_fire       = s_axi_arvalid & s_axi_arready;
  wire   rd_cfg_hit    = (s_axi_araddr[7:4] == 4'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire   [1:0] rd_key  = s_axi_araddr[3:2];
  wire   rd_status     = (s_axi_araddr == KWU_STATUS_OFFSET);
  wire   rd_pullup     = (s_axi_araddr == KWU_PULLUP_OFFSET);
  wire   rd_route      = (s_axi_araddr == KWU_ROUTE_OFFSET);
  wire   rd_mapped     = rd_cfg_hit | rd_status | rd_pullup | rd_route;
  wire   status_clear  = ar_fire & rd_status;

  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_cfg_hit) begin
      rd_word[KWU_SEL_LSB +: 2] = sel_reg[rd_key];
      rd_word[KWU_EN_BIT]       = en_reg[rd_key];
    end else if (rd_status) begin
      rd_word[N-1:0] = status_reg;
    end else if (rd_pullup) begin
      rd_word[N-1:0] = pullup_reg;
    end else if (rd_route) begin
      rd_word[0] = route_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= KWU_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? KWU_RESP_OKAY : KWU_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ---------------- status flags ----------------
  // read clears all flags at once; a hit in the same cycle wins
  assign status_next = (status_clear ? {N{1'b0}} : status_reg) | key_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= {N{1'b0}};
    end else begin
      status_reg <= status_next;
    end
  end

  // ---------------- shared request ----------------
  wire any_req = |status_reg;
  assign key_wake_req = any_req & route_reg;
  assign key_irq_req  = any_req & ~route_reg;

  // ---------------- assertions ----------------
  flag_needs_enable_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 1) |-> ((status_reg & ~$past(status_reg, 1) & ~$past(en_reg, 1)) == 4'h0))
    else $error("flag set on a disabled key");

  disabled_no_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((en_reg == 4'h0) && status_clear) |=> (status_reg == 4'h0))
    else $error("disabled keys raised a flag");

  hit_sets_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (key_hit != 4'h0) |=> ((status_reg & $past(key_hit, 1)) == $past(key_hit, 1)))
    else $error("detected key did not set its flag");

  read_clears_all_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (status_clear && key_hit == 4'h0) |=> (status_reg == 4'h0))
    else $error("status read left flags set");

  read_returns_flags_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    status_clear |=> (rvalid_reg && rdata_reg[N-1:0] == $past(status_reg, 1)))
    else $error("status read returned wrong flags");

  write_no_status_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_status && !status_clear && key_hit == 4'h0) |=> (status_reg == $past(status_reg, 1)))
    else $error("write changed status");

  hit_beats_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (status_clear && key_hit != 4'h0) |=> (status_reg == $past(key_hit, 1)))
    else $error("detection lost under clear");

  level_holds_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (en_reg[0] && sel_reg[0] == KWU_SEL_HIGH && g_key[0].key_active) |=> status_reg[0])
    else $error("level flag dropped while input active");

  route_split_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (status_reg != 4'h0) |-> (key_wake_req == route_reg && key_irq_req == !route_reg))
    else $error("shared request misrouted");

  quiet_no_req_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (status_reg == 4'h0) |-> !(key_wake_req || key_irq_req))
    else $error("request without pending flag");

  sync_delay_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ($past(aresetn, 1) && $past(aresetn, 2)) |-> (g_key[1].u_detect.sync2_reg == $past(key_in[1], 2)))
    else $error("key seen without synchroniser delay");

  pullup_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_lane0 && wr_pullup) |=> (key_pullup_en == $past(w_data_reg[N-1:0], 1)))
    else $error("pull-up write not applied");

  strobe_ignored_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && !wr_lane0) |=> (key_pullup_en == $past(key_pullup_en, 1)))
    else $error("write without low lane changed pull-ups");

  route_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wr_lane0 && wr_route) |=> (route_reg == $past(w_data_reg[0], 1)))
    else $error("routing write not applied");

endmodule

// [kwu_key_switches.sv]
`timescale 1ns/1ns
// key switches to ground; an open pin without pull-up floats
module kwu_key_switches
  import kwu_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // switch state, 1 = pressed
  input  wire logic [3:0] press,
  input  wire logic [3:0] key_pullup_en,
  // pins
  output logic      [3:0] key_in
);
  logic [3:0] float_reg = 4'h5;

  // floating pins wander every cycle
  always_ff @(posedge aclk) begin
    float_reg <= ~float_reg;
  end

  assign key_in = ~press & (key_pullup_en | float_reg);
endmodule

// [key_wakeup_detector_bench.sv]
`timescale 1ns/1ns
module key_wakeup_detector_bench
  import kwu_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [3:0]  key_in;
  logic [3:0]  key_pullup_en;
  logic        key_irq_req;
  logic        key_wake_req;
  logic [3:0]  press = 4'h0;
  int          errors = 0;
  int          comparisons = 0;

  always #10 aclk = ~aclk;

  kwu_key_wakeup dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .key_in(key_in), .key_pullup_en(key_pullup_en),
    .key_irq_req(key_irq_req), .key_wake_req(key_wake_req)
  );

  kwu_key_switches keys (.aclk(aclk), .press(press), .key_pullup_en(key_pullup_en), .key_in(key_in));

  task automatic close_out();
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic hw, hd, hb;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      hw = s_axi_awvalid & s_axi_awready;
      hd = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (hw) s_axi_awvalid <= 1'b0;
      if (hd) s_axi_wvalid <= 1'b0;
      if (hb) begin
        s_axi_bready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
        return;
      end
    end
    errors++;
    close_out();
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ha, hr;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) begin
        s_axi_rready <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
        return;
      end
    end
    errors++;
    close_out();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_rd(a, KWU_RESP_OKAY, d);
    chk(d, exp);
  endtask

  task automatic reset_values();
    logic [31:0] d;
    for (int n = 0; n < KWU_NUM_KEYS; n++) rd_chk(KWU_CONFIG0_OFFSET + 8'(4 * n), 32'h0);
    rd_chk(KWU_PULLUP_OFFSET, {28'h0, KWU_PULLUP_RESET});
    rd_chk(KWU_ROUTE_OFFSET, {31'h0, KWU_ROUTE_RESET});
    axi_wr(KWU_STATUS_OFFSET, 32'hf, KWU_RESP_OKAY);
    rd_chk(KWU_STATUS_OFFSET, 32'h0);
    axi_rd(8'h1c, KWU_RESP_SLVERR, d);
    chk(d, 32'h0);
    axi_wr(8'h1c, 32'hf, KWU_RESP_SLVERR);
    chk({26'h0, key_pullup_en, key_wake_req, key_irq_req}, 32'h0);
    // write without the low byte lane must be ignored
    s_axi_wstrb <= 4'he;
    axi_wr(KWU_PULLUP_OFFSET, 32'hf, KWU_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    chk({28'h0, key_pullup_en}, 32'h0);
  endtask

  // pull-up first, enable, settle, select, clear, routing
  task automatic setup_pullups();
    logic [31:0] d;
    axi_wr(KWU_PULLUP_OFFSET, 32'hf, KWU_RESP_OKAY);
    chk({28'h0, key_pullup_en}, 32'hf);
    for (int n = 0; n < KWU_NUM_KEYS; n++) axi_wr(KWU_CONFIG0_OFFSET + 8'(4 * n), 32'h10, KWU_RESP_OKAY);
    cyc(10);
    for (int n = 0; n < KWU_NUM_KEYS; n++) begin
      axi_wr(KWU_CONFIG0_OFFSET + 8'(4 * n), {27'h0, 1'b1, 2'h0, KWU_SEL_RISE}, KWU_RESP_OKAY);
    end
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    axi_wr(KWU_ROUTE_OFFSET, 32'h0, KWU_RESP_OKAY);
  endtask

  task automatic one_mode(input int n, input logic [1:0] sel);
    logic [31:0] d;
    logic idle, lvl;
    idle = !(sel == KWU_SEL_RISE || sel == KWU_SEL_HIGH);
    lvl = (sel == KWU_SEL_HIGH || sel == KWU_SEL_LOW);
    press[n] <= ~idle;
    cyc(6);
    axi_wr(KWU_CONFIG0_OFFSET + 8'(4 * n), {30'h0, sel}, KWU_RESP_OKAY);
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    axi_wr(KWU_CONFIG0_OFFSET + 8'(4 * n), {27'h0, 1'b1, 2'h0, sel}, KWU_RESP_OKAY);
    rd_chk(KWU_CONFIG0_OFFSET + 8'(4 * n), {27'h0, 1'b1, 2'h0, sel});
    chk({30'h0, key_wake_req, key_irq_req}, 32'h0);
    press[n] <= idle;
    cyc(6);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h1);
    rd_chk(KWU_STATUS_OFFSET, 32'h1 << n);
    rd_chk(KWU_STATUS_OFFSET, lvl ? 32'h1 << n : 32'h0);
    press[n] <= ~idle;
    cyc(6);
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    rd_chk(KWU_STATUS_OFFSET, 32'h0);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h0);
    axi_wr(KWU_CONFIG0_OFFSET + 8'(4 * n), 32'h0, KWU_RESP_OKAY);
  endtask

  task automatic multi_route();
    logic [31:0] d;
    press <= 4'h0;
    axi_wr(KWU_ROUTE_OFFSET, 32'h1, KWU_RESP_OKAY);
    rd_chk(KWU_ROUTE_OFFSET, 32'h1);
    axi_wr(KWU_CONFIG0_OFFSET, {27'h0, 1'b1, 2'h0, KWU_SEL_FALL}, KWU_RESP_OKAY);
    axi_wr(KWU_CONFIG1_OFFSET, {27'h0, 1'b1, 2'h0, KWU_SEL_FALL}, KWU_RESP_OKAY);
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    press <= 4'h3;
    cyc(6);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h2);
    rd_chk(KWU_STATUS_OFFSET, 32'h3);
    rd_chk(KWU_STATUS_OFFSET, 32'h0);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h0);
    press <= 4'h2;
    cyc(6);
    press <= 4'h3;
    cyc(6);
    rd_chk(KWU_STATUS_OFFSET, 32'h1);
    // run-time select change with key 0 left enabled, then keys 0 and 1 disabled
    axi_wr(KWU_CONFIG0_OFFSET, {27'h0, 1'b1, 2'h0, KWU_SEL_HIGH}, KWU_RESP_OKAY);
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h0);
    press <= 4'h2;
    cyc(6);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h2);
    rd_chk(KWU_STATUS_OFFSET, 32'h1);
    axi_wr(KWU_CONFIG0_OFFSET, 32'h0, KWU_RESP_OKAY);
    axi_wr(KWU_CONFIG1_OFFSET, 32'h0, KWU_RESP_OKAY);
    axi_wr(KWU_ROUTE_OFFSET, 32'h0, KWU_RESP_OKAY);
    press <= 4'h0;
  endtask

  // disabled keys on floating pins must stay silent
  task automatic floating_keys();
    logic [31:0] d;
    axi_wr(KWU_PULLUP_OFFSET, 32'h0, KWU_RESP_OKAY);
    chk({28'h0, key_pullup_en}, 32'h0);
    axi_rd(KWU_STATUS_OFFSET, KWU_RESP_OKAY, d);
    cyc(20);
    chk({30'h0, key_wake_req, key_irq_req}, 32'h0);
    rd_chk(KWU_STATUS_OFFSET, 32'h0);
  endtask

  initial begin
    cyc(12);
    aresetn <= 1'b1;
    reset_values();
    setup_pullups();
    for (int n = 0; n < KWU_NUM_KEYS; n++) begin
      for (int s = 0; s < 4; s++) one_mode(n, 2'(s));
    end
    multi_route();
    floating_keys();
    close_out();
  end
endmodule
